// ===== core/pfc_pkg.sv
// Purpose: Shared constants and types for the program flow control block
// Assumes: Byte-wide data memory, 12-bit program space
// Notes: Widths are fixed; reset values are plain defaults

package pfc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PC_W = 12;
	localparam int DA_W = 8;
	localparam int DW = 8;

	// ----------------------------------------
	// Reset values and steps
	// ----------------------------------------
	localparam logic [PC_W-1:0] PC_RST = 12'h000;
	localparam logic [DA_W-1:0] SP_RST = 8'h00;
	localparam logic GIE_RST = 1'b0;
	localparam logic [DA_W-1:0] SP_STEP = 8'h02;
	localparam logic [DA_W-1:0] HI_BYTE_OFS = 8'h01;
	localparam logic [PC_W-1:0] PC_STEP = 12'h001;
	localparam int HI_LSB = 8;

	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		PFC_OP_NOP = 4'h0,
		PFC_OP_CALL = 4'h1,
		PFC_OP_GOTO = 4'h2,
		PFC_OP_RET_IMM = 4'h3,
		PFC_OP_RET = 4'h4,
		PFC_OP_RETI = 4'h5,
		PFC_OP_PC_ADD = 4'h6,
		PFC_OP_INT_EN = 4'h7,
		PFC_OP_INT_DIS = 4'h8,
		PFC_OP_HALT = 4'h9
	} pfc_op_t;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		PFC_ST_IDLE = 3'b000,
		PFC_ST_PUSH_HI = 3'b001,
		PFC_ST_POP_LO = 3'b010,
		PFC_ST_POP_HI = 3'b011,
		PFC_ST_HALT = 3'b100
	} pfc_state_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		pfc_op_t op;
		logic [PC_W-1:0] target;
		logic [DW-1:0] imm;
	} pfc_req_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [DA_W-1:0] addr;
		logic [DW-1:0] wdata;
	} pfc_mem_t;

endpackage

// ===== core/pfc_next_pc.sv
// Purpose: Next program counter for single-cycle flow operations
// Assumes: Accumulator is taken as unsigned
// Notes: Purely combinational; wraps within program space

`timescale 1ns/1ps
`default_nettype none

module pfc_next_pc
	import pfc_pkg::*;
(
	input wire pfc_op_t op,
	input wire logic [PC_W-1:0] pc,
	input wire logic [PC_W-1:0] target,
	input wire logic [DW-1:0] acc,
	output logic [PC_W-1:0] next_pc,
	output logic [PC_W-1:0] ret_addr
);

	wire [PC_W-1:0] pc_inc;
	wire [PC_W-1:0] pc_plus_acc;
	wire use_target;
	wire use_acc;

	assign pc_inc = pc + PC_STEP;
	// [RULE_06] Unsigned table offset
	assign pc_plus_acc = pc + {{(PC_W-DW){1'b0}}, acc};
	// [RULE_02] Full range target
	assign use_target = (op == PFC_OP_GOTO) || (op == PFC_OP_CALL);
	assign use_acc = (op == PFC_OP_PC_ADD);
	assign next_pc = use_target ? target : (use_acc ? pc_plus_acc : pc_inc);
	assign ret_addr = pc_inc;

endmodule

`default_nettype wire

// ===== core/pfc_core.sv
// Purpose: Program flow and system control execution for an 8-bit core
// Assumes: Byte memory read data arrives in the same cycle as the read strobe
// Notes: Requests are taken only while ready_q is high
//
// Notes on behaviour
// [RULE_01] Call stores next address at stack pointer, jumps, then stack pointer plus two.
// [RULE_02] Jump loads program counter with target anywhere in program space.
// [RULE_03] Return with immediate writes immediate to accumulator, then returns.
// [RULE_04] Return subtracts two from stack pointer, reloads program counter from there.
// [RULE_05] Interrupt return restores program counter and sets global interrupt enable.
// [RULE_06] Computed jump adds unsigned accumulator to current program counter.
// [RULE_07] Interrupt enable instruction sets the global interrupt enable.
// [RULE_08] Interrupt disable instruction clears the global interrupt enable.
// [RULE_09] Halt stops system clocks until wake-up or reset.
// [RULE_10] No flags altered; no-operation only advances program counter.
// [RULE_11] Each stack entry is two consecutive bytes, low byte first.

`timescale 1ns/1ps
`default_nettype none

module pfc_core
	import pfc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire pfc_req_t req,
	input wire logic [DW-1:0] acc_in,
	input wire logic [DW-1:0] mem_rdata,
	input wire logic wake,
	output logic ready_q,
	output logic done_q,
	output logic [PC_W-1:0] program_counter_q,
	output logic [DA_W-1:0] stack_pointer_q,
	output logic gie_q,
	output logic halt_q,
	output logic acc_we_q,
	output logic [DW-1:0] accumulator_register_q,
	output pfc_mem_t mem_q
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	pfc_state_t state_q;
	pfc_state_t state_d;
	logic [DW-1:0] lo_byte_q;
	logic [PC_W-1:0] ret_addr_q;
	logic [PC_W-1:0] target_q;
	logic reti_q;
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] ret_addr;

	wire take;
	wire op_call;
	wire op_ret_any;
	wire op_ret_imm;
	wire op_reti;
	wire op_halt;
	wire op_simple;
	wire [DA_W-1:0] sp_up;
	wire [DA_W-1:0] sp_down;
	wire [DW-1:0] ret_hi_byte;
	wire [PC_W-1:0] popped_pc;

	assign take = req.valid && ready_q;
	assign op_call = take && (req.op == PFC_OP_CALL);
	assign op_ret_imm = take && (req.op == PFC_OP_RET_IMM);
	assign op_reti = take && (req.op == PFC_OP_RETI);
	assign op_ret_any = op_ret_imm || op_reti || (take && (req.op == PFC_OP_RET));
	assign op_halt = take && (req.op == PFC_OP_HALT);
	// Goto, computed jump, nop and interrupt enable ops finish in one cycle
	assign op_simple = take && !op_call && !op_ret_any && !op_halt;
	// [RULE_01] Stack grows by two
	assign sp_up = stack_pointer_q + SP_STEP;
	// [RULE_04] Stack shrinks by two first
	assign sp_down = stack_pointer_q - SP_STEP;
	// [RULE_11] High byte holds upper address bits
	assign ret_hi_byte = {{(2*DW-PC_W){1'b0}}, ret_addr_q[PC_W-1:HI_LSB]};
	assign popped_pc = {mem_rdata[PC_W-HI_LSB-1:0], lo_byte_q};

	pfc_next_pc u_next_pc
	(
		.op(req.op),
		.pc(program_counter_q),
		.target(req.target),
		.acc(acc_in),
		.next_pc(next_pc),
		.ret_addr(ret_addr)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			PFC_ST_IDLE:
			begin
				if (op_call)
					state_d = PFC_ST_PUSH_HI;
				else if (op_ret_any)
					state_d = PFC_ST_POP_LO;
				else if (op_halt)
					state_d = PFC_ST_HALT;
				else
					state_d = PFC_ST_IDLE;
			end
			PFC_ST_PUSH_HI:
				state_d = PFC_ST_IDLE;
			PFC_ST_POP_LO:
				state_d = PFC_ST_POP_HI;
			PFC_ST_POP_HI:
				state_d = PFC_ST_IDLE;
			PFC_ST_HALT:
			begin
				// [RULE_09] Held until wake
				if (wake)
					state_d = PFC_ST_IDLE;
				else
					state_d = PFC_ST_HALT;
			end
			default:
				state_d = PFC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= PFC_ST_IDLE;
			ready_q <= 1'b0;
			halt_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= (state_d == PFC_ST_IDLE);
			// [RULE_09] Clock stop request
			halt_q <= (state_d == PFC_ST_HALT);
		end
	end

	// ----------------------------------------
	// Latched operands
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ret_addr_q <= PC_RST;
			target_q <= PC_RST;
			reti_q <= 1'b0;
			lo_byte_q <= '0;
		end
		else
		begin
			if (take)
			begin
				ret_addr_q <= ret_addr;
				target_q <= req.target;
				reti_q <= op_reti;
			end
			if (state_q == PFC_ST_POP_LO)
				lo_byte_q <= mem_rdata;
		end
	end

	// ----------------------------------------
	// Program counter and stack pointer
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			program_counter_q <= PC_RST;
			stack_pointer_q <= SP_RST;
		end
		else
		begin
			// [RULE_10] Nop only advances
			if (op_simple || op_halt)
				program_counter_q <= next_pc;
			// [RULE_01] Jump after push
			else if (state_q == PFC_ST_PUSH_HI)
			begin
				program_counter_q <= target_q;
				stack_pointer_q <= sp_up;
			end
			// [RULE_04] Pop before restore
			else if (op_ret_any)
				stack_pointer_q <= sp_down;
			// [RULE_05] Restore from stack
			else if (state_q == PFC_ST_POP_HI)
				program_counter_q <= popped_pc;
		end
	end

	// ----------------------------------------
	// Data memory port
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			mem_q <= '0;
		else
		begin
			mem_q <= '0;
			// [RULE_11] Low byte at stack pointer
			if (op_call)
			begin
				mem_q.we <= 1'b1;
				mem_q.addr <= stack_pointer_q;
				mem_q.wdata <= ret_addr[DW-1:0];
			end
			else if (state_q == PFC_ST_PUSH_HI)
			begin
				mem_q.we <= 1'b1;
				mem_q.addr <= stack_pointer_q + HI_BYTE_OFS;
				mem_q.wdata <= ret_hi_byte;
			end
			// [RULE_04] Read at lowered pointer
			else if (op_ret_any)
			begin
				mem_q.re <= 1'b1;
				mem_q.addr <= sp_down;
			end
			else if (state_q == PFC_ST_POP_LO)
			begin
				mem_q.re <= 1'b1;
				mem_q.addr <= stack_pointer_q + HI_BYTE_OFS;
			end
		end
	end

	// ----------------------------------------
	// Accumulator, interrupt enable, completion
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc_we_q <= 1'b0;
			accumulator_register_q <= '0;
			gie_q <= GIE_RST;
			done_q <= 1'b0;
		end
		else
		begin
			// [RULE_03] Immediate before return
			acc_we_q <= op_ret_imm;
			if (op_ret_imm)
				accumulator_register_q <= req.imm;
			// [RULE_07] Enable
			if (take && (req.op == PFC_OP_INT_EN))
				gie_q <= 1'b1;
			// [RULE_08] Disable
			else if (take && (req.op == PFC_OP_INT_DIS))
				gie_q <= 1'b0;
			// [RULE_05] Enable on completion
			else if ((state_q == PFC_ST_POP_HI) && reti_q)
				gie_q <= 1'b1;
			// Halt counts as done when it is entered, not at wake
			done_q <= op_simple || op_halt || (state_q == PFC_ST_PUSH_HI)
				|| (state_q == PFC_ST_POP_HI);
		end
	end

endmodule

`default_nettype wire

// ===== tb/pfc_core_chk.sv
// Purpose: Port assertions for pfc_core
// Assumes: One clock, async reset
// Notes: Bound to pfc_core
`timescale 1ns/1ps
`default_nettype none
module pfc_core_chk
	import pfc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire pfc_req_t req,
	input wire logic [DW-1:0] acc_in,
	input wire logic ready_q,
	input wire logic done_q,
	input wire logic [PC_W-1:0] program_counter_q,
	input wire logic [DA_W-1:0] stack_pointer_q,
	input wire logic gie_q,
	input wire logic halt_q,
	input wire logic acc_we_q,
	input wire logic [DW-1:0] accumulator_register_q,
	input wire pfc_mem_t mem_q
);
	// ----
	// Checks
	// ----
	logic [15:0] hit;
	logic [PC_W-1:0] ra;
	assign hit = (req.valid && ready_q) ? (16'h0001 << req.op) : 16'h0000;
	assign ra = program_counter_q + PC_STEP;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_call_push: assert property (hit[PFC_OP_CALL] |=> mem_q.we &&
		mem_q.addr == $past(stack_pointer_q) && mem_q.wdata == $past(ra[7:0]) ##1 mem_q.we &&
		mem_q.addr == $past(stack_pointer_q, 2) + HI_BYTE_OFS &&
		mem_q.wdata == 8'($past(ra, 2) >> 8) && done_q &&
		program_counter_q == $past(req.target, 2)) else $error("call wrong");
	a_call_sp: assert property (hit[PFC_OP_CALL] |=> ##1
		stack_pointer_q == $past(stack_pointer_q, 2) + SP_STEP) else $error("call sp");
	a_ret_pop: assert property (hit[PFC_OP_RET] || hit[PFC_OP_RETI] |=> mem_q.re &&
		stack_pointer_q == $past(stack_pointer_q) - SP_STEP && mem_q.addr == stack_pointer_q
		##2 done_q) else $error("ret pop");
	a_imm_acc: assert property (hit[PFC_OP_RET_IMM] |=> acc_we_q &&
		accumulator_register_q == $past(req.imm)) else $error("ret imm acc");
	a_reti_gie: assert property (hit[PFC_OP_RETI] |=> !done_q ##2 gie_q && done_q)
		else $error("reti gie");
	a_goto_pc: assert property (hit[PFC_OP_GOTO] |=> done_q &&
		program_counter_q == $past(req.target)) else $error("goto pc");
	a_pc_add: assert property (hit[PFC_OP_PC_ADD] |=>
		program_counter_q == $past(program_counter_q) + 12'($past(acc_in))) else $error("pc add");
	a_gie_set: assert property (hit[PFC_OP_INT_EN] |=> gie_q) else $error("gie set");
	a_gie_clr: assert property (hit[PFC_OP_INT_DIS] |=> !gie_q) else $error("gie clr");
	a_halt_on: assert property (hit[PFC_OP_HALT] |=> halt_q && !ready_q) else $error("halt");
	a_nop_only: assert property (hit[PFC_OP_NOP] |=> $stable(stack_pointer_q) &&
		$stable(gie_q) && program_counter_q == $past(ra)) else $error("nop");
	c_call: cover property (hit[PFC_OP_CALL]);
	c_reti: cover property (hit[PFC_OP_RETI]);
	c_wake: cover property (halt_q ##1 !halt_q);
endmodule
bind pfc_core pfc_core_chk u_pfc_core_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
	.acc_in(acc_in), .ready_q(ready_q), .done_q(done_q), .program_counter_q(program_counter_q),
	.stack_pointer_q(stack_pointer_q), .gie_q(gie_q), .halt_q(halt_q), .acc_we_q(acc_we_q),
	.accumulator_register_q(accumulator_register_q), .mem_q(mem_q));
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Directed bench for pfc_core
// Assumes: Byte stack memory modelled here
// Notes: Read data stands in the cycle the read strobe stands
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pfc_pkg::*;
	// ----
	// Bench
	// ----
	logic clk_sys, sys_rst, wake, ready_q, done_q, gie_q, halt_q, acc_we_q;
	pfc_req_t req;
	logic [DW-1:0] acc_in, mem_rdata, acc_seen, accumulator_register_q;
	logic [PC_W-1:0] program_counter_q, p;
	logic [DA_W-1:0] stack_pointer_q;
	pfc_mem_t mem_q;
	logic [DW-1:0] stk [256];
	int fail_count = 0;
	int checks = 0;
	pfc_core u_pfc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .acc_in(acc_in),
		.mem_rdata(mem_rdata), .wake(wake), .ready_q(ready_q), .done_q(done_q),
		.program_counter_q(program_counter_q), .stack_pointer_q(stack_pointer_q),
		.gie_q(gie_q), .halt_q(halt_q), .acc_we_q(acc_we_q),
		.accumulator_register_q(accumulator_register_q), .mem_q(mem_q));
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Idle read data shows the inverse byte so stale bytes never pass
	assign mem_rdata = mem_q.re ? stk[mem_q.addr] : ~stk[mem_q.addr];
	always @(posedge clk_sys)
	begin
		if (mem_q.we)
			stk[mem_q.addr] <= mem_q.wdata;
		if (acc_we_q)
			acc_seen <= accumulator_register_q;
	end
	task automatic wrap_up();
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic go(input pfc_op_t op, input logic [11:0] t, input logic [7:0] i);
		int n;
		req <= '{1'b1, op, t, i};
		@(posedge clk_sys);
		req.valid <= 1'b0;
		for (n = 0; n < 8 && done_q !== 1'b1; n++)
			@(posedge clk_sys);
		chk("done", 12'h001, done_q);
		if (done_q !== 1'b1)
			wrap_up();
	endtask
	task automatic t_reset();
		chk("pc", PC_RST, program_counter_q);
		chk("sp", SP_RST, stack_pointer_q);
		chk("gie", GIE_RST, gie_q);
	endtask
	task automatic t_flow();
		go(PFC_OP_NOP, 12'hFFF, 8'hFF);
		chk("pc", 12'h001, program_counter_q);
		chk("sp", 12'h000, stack_pointer_q);
		go(PFC_OP_GOTO, 12'hFFF, 8'h00);
		chk("pc", 12'hFFF, program_counter_q);
		acc_in <= 8'hFF;
		go(PFC_OP_PC_ADD, 12'h000, 8'h00);
		chk("pc", 12'h0FE, program_counter_q);
	endtask
	task automatic t_gie();
		go(PFC_OP_INT_EN, 12'h000, 8'h00);
		chk("gie", 12'h001, gie_q);
		go(PFC_OP_INT_DIS, 12'h000, 8'h00);
		chk("gie", 12'h000, gie_q);
	endtask
	task automatic t_stack();
		go(PFC_OP_GOTO, 12'h8FF, 8'h00);
		go(PFC_OP_CALL, 12'hABC, 8'h00);
		chk("pc", 12'hABC, program_counter_q);
		chk("sp", 12'h002, stack_pointer_q);
		// Bench memory stores the high byte on this edge
		@(posedge clk_sys);
		chk("lo", 12'h000, stk[0]);
		chk("hi", 12'h009, stk[1]);
		go(PFC_OP_CALL, 12'h123, 8'h00);
		go(PFC_OP_RET_IMM, 12'h000, 8'h5A);
		chk("acc", 12'h05A, acc_seen);
		chk("pc", 12'hABD, program_counter_q);
		chk("sp", 12'h002, stack_pointer_q);
		go(PFC_OP_RETI, 12'h000, 8'h00);
		chk("pc", 12'h900, program_counter_q);
		chk("gie", 12'h001, gie_q);
	endtask
	task automatic t_halt();
		int n;
		p = program_counter_q + PC_STEP;
		go(PFC_OP_HALT, 12'h000, 8'h00);
		chk("halt", 12'h001, halt_q);
		req <= '{1'b1, PFC_OP_NOP, 12'h000, 8'h00};
		repeat (3) @(posedge clk_sys);
		chk("pc", p, program_counter_q);
		req.valid <= 1'b0;
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		for (n = 0; n < 8 && ready_q !== 1'b1; n++)
			@(posedge clk_sys);
		chk("ready", 12'h001, ready_q);
		chk("halt", 12'h000, halt_q);
		if (ready_q !== 1'b1)
			wrap_up();
	endtask
	task automatic t_rst();
		go(PFC_OP_HALT, 12'h000, 8'h00);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk("ready", 12'h000, ready_q);
		@(posedge clk_sys);
		chk("ready", 12'h001, ready_q);
		chk("halt", 12'h000, halt_q);
		chk("pc", PC_RST, program_counter_q);
		chk("sp", SP_RST, stack_pointer_q);
		chk("gie", GIE_RST, gie_q);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		wake = 1'b0;
		acc_in = 8'h00;
		req = '0;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_flow();
		t_gie();
		t_stack();
		t_halt();
		t_rst();
		wrap_up();
	end
endmodule
`default_nettype wire
